// ### rtl/nvac_ctrl.sv
// data eeprom and program memory indirect access controller
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module nvac_ctrl #(
  parameter int PROG_WORDS   = 4096,
  parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES,
  parameter int ERASE_CYCLES = nvac_pkg::ERASE_CYCLES
) (
  input  wire logic        CLK,           // core clock, 125 MHz
  input  wire logic        SYS_RST,       // synchronous reset, high
  input  wire logic        POR,           // power-up reset, high
  input  wire logic        EXT_RST,       // external pin or watchdog reset, high
  input  wire logic        CODE_PROTECT,  // code protection active
  input  wire logic [1:0]  SELF_PROGRAM_LOCK, // self-write protect field, unused since program space is never written
  input  wire logic        PSEL,          // apb select
  input  wire logic        PENABLE,       // apb access phase
  input  wire logic        PWRITE,        // apb direction
  input  wire logic [7:0]  PADDR,         // apb byte address
  input  wire logic [31:0] PWDATA,        // apb write data
  input  wire logic [3:0]  PSTRB,         // apb byte strobes
  output logic             PREADY,        // apb ready
  output logic      [31:0] PRDATA,        // apb read data
  output logic             PSLVERR,       // apb error
  input  wire logic        PGM_REQ,       // external programmer request
  input  wire logic [7:0]  PGM_ADDR,      // programmer data address
  output logic             PGM_GRANT,     // programmer access granted
  output logic      [7:0]  PGM_RDATA,     // programmer read data
  output logic      [12:0] PROG_ADDR,     // program store word address
  input  wire logic [13:0] PROG_RDATA,    // program store word
  output logic             BUSY           // write cycle in progress
);
  localparam int PAW = $clog2(PROG_WORDS);
  localparam logic [nvac_pkg::PROG_ADDR_W-1:0] PROG_MASK =
    nvac_pkg::PROG_ADDR_W'(PROG_WORDS - 1);

  // program words come from a store outside this block
  logic [7:0]  data_low_ff;
  logic [7:0]  addr_low_ff;
  logic [nvac_pkg::DATA_HI_W-1:0] data_high_ff;
  logic [nvac_pkg::ADDR_HI_W-1:0] addr_high_ff;
  logic        space_ff;
  logic        permit_ff;
  logic        abort_ff;
  logic        rd_ff;
  logic        wr_ff;
  logic        rd_pend_ff;
  logic        done_ff;
  logic [1:0]  key_ff;
  nvac_pkg::nvac_state_e state_ff;
  logic [15:0] tmr_ff;
  logic [7:0]  mem_rdata;
  logic        mem_we;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_addr;

  // apb decode
  logic acc;
  logic wr_acc;
  logic [7:0] wb;
  assign acc    = PSEL && PENABLE && PREADY;
  assign wr_acc = acc && PWRITE && PSTRB[0];
  assign wb     = PWDATA[7:0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, nvac_pkg::OFS_DATA_LOW) || hit(a, nvac_pkg::OFS_ADDR_LOW)
          || hit(a, nvac_pkg::OFS_DATA_HIGH) || hit(a, nvac_pkg::OFS_ADDR_HIGH)
          || hit(a, nvac_pkg::OFS_CONTROL) || hit(a, nvac_pkg::OFS_UNLOCK)
          || hit(a, nvac_pkg::OFS_FLAGS2);
  endfunction : mapped

  // full reach of the address pair
  logic [nvac_pkg::PROG_ADDR_W-1:0] prog_addr;
  assign prog_addr = {addr_high_ff, addr_low_ff};
  // address wraps inside the fitted store size
  assign PROG_ADDR = prog_addr & PROG_MASK;

  // quarters from the bottom up to ~lock locked by field value; 11 locks none
  function automatic logic prog_locked(input logic [1:0] lock,
                                       input logic [nvac_pkg::PROG_ADDR_W-1:0] a);
    logic [1:0] blk;
    blk = a[PAW-1 -: 2];
    prog_locked = (lock == 2'b11) ? 1'b0 : (blk <= ~lock);
  endfunction : prog_locked

  // trigger set conditions
  logic ctl_wr;
  logic start_rd;
  logic start_wr;
  assign ctl_wr   = wr_acc && hit(PADDR, nvac_pkg::OFS_CONTROL);
  assign start_rd = ctl_wr && wb[nvac_pkg::CTL_RD_BIT] && !rd_ff && !wr_ff;
  assign start_wr = ctl_wr && wb[nvac_pkg::CTL_WR_BIT] && !wr_ff
                 && permit_ff && !wb[nvac_pkg::CTL_SPACE_BIT] && !space_ff
                 && key_ff == 2'd2;

  // external programmer only when not protected and idle
  logic pgm_ok;
  assign pgm_ok = PGM_REQ && !CODE_PROTECT && state_ff == nvac_pkg::ST_IDLE;

  // erase writes blank byte, then program writes the value
  always_comb begin
    mem_we    = 1'b0;
    mem_wdata = 8'hFF;
    // programmer borrows the read port only while no write runs
    mem_addr  = pgm_ok ? PGM_ADDR : addr_low_ff;
    if (state_ff == nvac_pkg::ST_ERASE && tmr_ff == 16'h0000) begin
      mem_we = 1'b1;
    end
    if (state_ff == nvac_pkg::ST_PROGRAM && tmr_ff == 16'h0000) begin
      mem_we    = 1'b1;
      mem_wdata = data_low_ff;
    end
  end

  nvac_mem #(.AW(8), .DW(8)) u_mem (
    .clk   (CLK),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // write cycle sequenced by internal timer
  always_ff @(posedge CLK) begin
    if (SYS_RST || EXT_RST) begin
      state_ff <= nvac_pkg::ST_IDLE;
      tmr_ff   <= 16'h0000;
    end else begin
      unique case (state_ff)
        nvac_pkg::ST_IDLE: begin
          if (start_wr) begin
            state_ff <= nvac_pkg::ST_ERASE;
            tmr_ff   <= 16'(ERASE_CYCLES - 1);
          end
        end
        nvac_pkg::ST_ERASE: begin
          if (tmr_ff == 16'h0000) begin
            state_ff <= nvac_pkg::ST_PROGRAM;
            tmr_ff   <= 16'(WRITE_CYCLES - ERASE_CYCLES - 1);
          end else begin
            tmr_ff <= tmr_ff - 16'h0001;
          end
        end
        nvac_pkg::ST_PROGRAM: begin
          if (tmr_ff == 16'h0000) begin
            state_ff <= nvac_pkg::ST_IDLE;
          end else begin
            tmr_ff <= tmr_ff - 16'h0001;
          end
        end
        default: begin
          state_ff <= nvac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  logic wr_done;
  assign wr_done = state_ff == nvac_pkg::ST_PROGRAM && tmr_ff == 16'h0000;

  // unlock key tracker: two keys in order arm one write
  always_ff @(posedge CLK) begin
    if (SYS_RST || EXT_RST) begin
      key_ff <= 2'd0;
    end else if (wr_acc && hit(PADDR, nvac_pkg::OFS_UNLOCK)) begin
      if (wb == nvac_pkg::KEY_FIRST) begin
        key_ff <= 2'd1;
      end else if (wb == nvac_pkg::KEY_SECOND && key_ff == 2'd1) begin
        key_ff <= 2'd2;
      end else begin
        key_ff <= 2'd0;
      end
    end else if (wr_acc || start_wr) begin
      key_ff <= 2'd0;
    end
  end

  // triggers set by software, cleared by hardware
  always_ff @(posedge CLK) begin
    if (SYS_RST || EXT_RST) begin
      rd_ff      <= 1'b0;
      wr_ff      <= 1'b0;
      rd_pend_ff <= 1'b0;
    end else begin
      rd_ff      <= start_rd;
      rd_pend_ff <= start_rd;
      if (start_wr) begin
        wr_ff <= 1'b1;
      end else if (wr_done) begin
        wr_ff <= 1'b0;
      end
    end
  end

  // space select, permit clear at reset
  always_ff @(posedge CLK) begin
    if (SYS_RST || EXT_RST) begin
      space_ff  <= 1'b0;
      permit_ff <= 1'b0;
    end else if (ctl_wr) begin
      space_ff  <= wb[nvac_pkg::CTL_SPACE_BIT];
      permit_ff <= wb[nvac_pkg::CTL_PERM_BIT];
    end
  end

  // abort flag survives external reset, cleared by power-up or a control write
  always_ff @(posedge CLK) begin
    if (POR) begin
      abort_ff <= 1'b0;
    end else if (EXT_RST && state_ff != nvac_pkg::ST_IDLE) begin
      abort_ff <= 1'b1;
    end else if (ctl_wr) begin
      abort_ff <= wb[nvac_pkg::CTL_ABORT_BIT];
    end
  end

  // done flag, set wins over a software clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      done_ff <= 1'b0;
    end else if (wr_done) begin
      done_ff <= 1'b1;
    end else if (wr_acc && hit(PADDR, nvac_pkg::OFS_FLAGS2)) begin
      done_ff <= wb[nvac_pkg::FLG_DONE_BIT];
    end
  end

  logic [nvac_pkg::PROG_WORD_W-1:0] prog_word;
  assign prog_word = PROG_RDATA;

  // data registers updated the cycle after the trigger
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      data_low_ff  <= nvac_pkg::RST_BYTE;
      data_high_ff <= '0;
    end else if (rd_pend_ff && space_ff) begin
      data_low_ff  <= prog_word[7:0];
      data_high_ff <= prog_word[nvac_pkg::PROG_WORD_W-1:8];
    end else if (rd_pend_ff) begin
      data_low_ff <= mem_rdata;
    end else if (wr_acc && hit(PADDR, nvac_pkg::OFS_DATA_LOW) && !wr_ff) begin
      data_low_ff <= wb;
    end else if (wr_acc && hit(PADDR, nvac_pkg::OFS_DATA_HIGH)) begin
      data_high_ff <= wb[nvac_pkg::DATA_HI_W-1:0];
    end
  end

  // software loads address bytes; held stable during a write
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      addr_low_ff  <= nvac_pkg::RST_BYTE;
      addr_high_ff <= '0;
    end else if (wr_acc && !wr_ff) begin
      if (hit(PADDR, nvac_pkg::OFS_ADDR_LOW)) begin
        addr_low_ff <= wb;
      end
      if (hit(PADDR, nvac_pkg::OFS_ADDR_HIGH)) begin
        addr_high_ff <= wb[nvac_pkg::ADDR_HI_W-1:0];
      end
    end
  end

  // external programmer path, one cycle behind grant
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PGM_GRANT <= 1'b0;
      PGM_RDATA <= 8'h00;
    end else begin
      PGM_GRANT <= pgm_ok;
      PGM_RDATA <= pgm_ok ? mem_rdata : 8'h00;
    end
  end

  // read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (PADDR)
      nvac_pkg::OFS_DATA_LOW:  rd_byte = data_low_ff;
      nvac_pkg::OFS_ADDR_LOW:  rd_byte = addr_low_ff;
      nvac_pkg::OFS_DATA_HIGH: rd_byte = {2'b00, data_high_ff};
      nvac_pkg::OFS_ADDR_HIGH: rd_byte = {3'b000, addr_high_ff};
      nvac_pkg::OFS_CONTROL:   rd_byte = {space_ff, 3'b000, abort_ff, permit_ff, wr_ff, rd_ff};
      nvac_pkg::OFS_UNLOCK:    rd_byte = 8'h00;
      nvac_pkg::OFS_FLAGS2:    rd_byte = {3'b000, done_ff, 4'h0};
      default:                 rd_byte = 8'h00;
    endcase
  end

  // no wait state: ready in the access phase's first cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      BUSY    <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped(PADDR);
      PRDATA  <= (PSEL && !PENABLE && !PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      // busy falls with the last program cycle, or at once on external reset
      BUSY    <= !EXT_RST && (((state_ff != nvac_pkg::ST_IDLE) && !wr_done) || start_wr);
    end
  end

endmodule : nvac_ctrl

// ### rtl/nvac_mem.sv
// byte array with registered read port
`timescale 1ns/1ps
module nvac_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk,    // core clock
  input  wire logic          we,     // write strobe
  input  wire logic [AW-1:0] addr,   // word address
  input  wire logic [DW-1:0] wdata,  // write data
  output logic      [DW-1:0] rdata   // registered read data
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : nvac_mem

// ### rtl/nvac_pkg.sv
// constants and types shared by the nonvolatile access controller
package nvac_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] OFS_DATA_LOW  = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h04;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h08;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] OFS_CONTROL   = 8'h10;
  localparam logic [7:0] OFS_UNLOCK    = 8'h14;
  localparam logic [7:0] OFS_FLAGS2    = 8'h18;
  // control register fields
  localparam int CTL_RD_BIT    = 0;
  localparam int CTL_WR_BIT    = 1;
  localparam int CTL_PERM_BIT  = 2;
  localparam int CTL_ABORT_BIT = 3;
  localparam int CTL_SPACE_BIT = 7;
  // flag register 2 field
  localparam int FLG_DONE_BIT  = 4;
  // field widths
  localparam int DATA_HI_W     = 6;
  localparam int ADDR_HI_W     = 5;
  localparam int PROG_WORD_W   = 14;
  localparam int PROG_ADDR_W   = 13;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // unlock sequence keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // write cycle time, erase then program
  localparam int WRITE_TIME_NS = 5000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES  = WRITE_CYCLES / 2;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ERASE   = 2'b01,
    ST_PROGRAM = 2'b11
  } nvac_state_e;
endpackage : nvac_pkg

// ### test/eeprom_flash_access_ctrl_bench.sv
// self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
module eeprom_flash_access_ctrl_bench;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        POR = 1'b1;
  logic        EXT_RST = 1'b0;
  logic        CODE_PROTECT = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic        PGM_REQ = 1'b0;
  logic [7:0]  PGM_ADDR = 8'h00;
  logic        PREADY, PSLVERR, PGM_GRANT, BUSY;
  logic [31:0] PRDATA;
  logic [7:0]  PGM_RDATA;
  logic [12:0] PROG_ADDR;
  logic [13:0] PROG_RDATA;
  logic [31:0] rdq;
  logic        errq;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [7:0]  ta [3] = '{8'h00, 8'hFF, 8'hFF};
  logic [7:0]  td [3] = '{8'hA5, 8'h5A, 8'hC3};
  nvac_ctrl #(.PROG_WORDS(4096), .WRITE_CYCLES(8), .ERASE_CYCLES(4)) dut (
    .CLK(CLK), .SYS_RST(SYS_RST), .POR(POR), .EXT_RST(EXT_RST),
    .CODE_PROTECT(CODE_PROTECT), .SELF_PROGRAM_LOCK(2'b00), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(4'hF), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .PGM_REQ(PGM_REQ), .PGM_ADDR(PGM_ADDR), .PGM_GRANT(PGM_GRANT),
    .PGM_RDATA(PGM_RDATA), .PROG_ADDR(PROG_ADDR), .PROG_RDATA(PROG_RDATA), .BUSY(BUSY));
  // program store stand-in: each word echoes its address under a set top bit
  assign PROG_RDATA = {1'b1, PROG_ADDR};
  always #4 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  // entered just after an edge; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 50) begin
      n++;
      @(posedge CLK);
    end
    if (n == 50) num_errors++;
    rdq = PRDATA;
    errq = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // idle edge so the next call never drives psel twice in one step
    @(posedge CLK);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdq, e);
  endtask : rd
  task automatic eewr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    wr(nvac_pkg::OFS_ADDR_LOW, {24'h00_0000, a});
    wr(nvac_pkg::OFS_DATA_LOW, {24'h00_0000, d});
    // permit and space settle before the keys; any other write drops them
    wr(nvac_pkg::OFS_CONTROL, {24'h00_0000, c & 8'hFC});
    wr(nvac_pkg::OFS_UNLOCK, {24'h00_0000, nvac_pkg::KEY_FIRST});
    wr(nvac_pkg::OFS_UNLOCK, {24'h00_0000, nvac_pkg::KEY_SECOND});
    wr(nvac_pkg::OFS_CONTROL, {24'h00_0000, c});
  endtask : eewr
  task automatic eerd(input logic [7:0] a, input logic [7:0] e);
    wr(nvac_pkg::OFS_ADDR_LOW, {24'h00_0000, a});
    wr(nvac_pkg::OFS_CONTROL, 32'h0000_0001);
    rd(nvac_pkg::OFS_DATA_LOW, {24'h00_0000, e});
  endtask : eerd
  task automatic wait_idle();
    int n;
    n = 0;
    while (BUSY !== 1'b0 && n < 100) begin
      n++;
      @(posedge CLK);
    end
    chk({31'h0000_0000, BUSY}, 32'h0000_0000);
  endtask : wait_idle
  initial begin
    cyc(10);
    SYS_RST <= 1'b0;
    POR <= 1'b0;
    cyc(1);
    rd(nvac_pkg::OFS_DATA_LOW, 32'h0000_0000);
    rd(nvac_pkg::OFS_ADDR_LOW, 32'h0000_0000);
    rd(nvac_pkg::OFS_CONTROL, 32'h0000_0000);
    wr(nvac_pkg::OFS_UNLOCK, 32'hFFFF_FFFF);
    rd(nvac_pkg::OFS_UNLOCK, 32'h0000_0000);
    wr(nvac_pkg::OFS_DATA_HIGH, 32'h0000_00FF);
    rd(nvac_pkg::OFS_DATA_HIGH, 32'h0000_003F);
    wr(nvac_pkg::OFS_ADDR_HIGH, 32'h0000_00FF);
    rd(nvac_pkg::OFS_ADDR_HIGH, 32'h0000_001F);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({31'h0000_0000, errq}, 32'h0000_0001);
    // overwrite of ff with bits that a program-only write could not reach
    for (int i = 0; i < 3; i++) begin
      eewr(ta[i], td[i], 8'h06);
      wr(nvac_pkg::OFS_CONTROL, 32'h0000_0004);
      chk({31'h0000_0000, BUSY}, 32'h0000_0001);
      rd(nvac_pkg::OFS_CONTROL, 32'h0000_0006);
      wait_idle();
      rd(nvac_pkg::OFS_CONTROL, 32'h0000_0004);
      rd(nvac_pkg::OFS_FLAGS2, 32'h0000_0010);
      wr(nvac_pkg::OFS_FLAGS2, 32'h0000_0000);
      rd(nvac_pkg::OFS_FLAGS2, 32'h0000_0000);
      eerd(ta[i], td[i]);
      rd(nvac_pkg::OFS_DATA_LOW, {24'h00_0000, td[i]});
    end
    eewr(8'h00, 8'h11, 8'h02);
    cyc(2);
    chk({31'h0000_0000, BUSY}, 32'h0000_0000);
    eerd(8'h00, 8'hA5);
    eewr(8'h00, 8'h22, 8'h86);
    cyc(2);
    chk({31'h0000_0000, BUSY}, 32'h0000_0000);
    eerd(8'h00, 8'hA5);
    wr(nvac_pkg::OFS_ADDR_LOW, 32'h0000_003C);
    wr(nvac_pkg::OFS_CONTROL, 32'h0000_0081);
    rd(nvac_pkg::OFS_CONTROL, 32'h0000_0080);
    // address bit 12 lies beyond the 4K store and must not reach it
    rd(nvac_pkg::OFS_DATA_LOW, 32'h0000_003C);
    rd(nvac_pkg::OFS_DATA_HIGH, 32'h0000_002F);
    eewr(8'h10, 8'h77, 8'h06);
    cyc(2);
    EXT_RST <= 1'b1;
    cyc(1);
    EXT_RST <= 1'b0;
    cyc(1);
    chk({31'h0000_0000, BUSY}, 32'h0000_0000);
    rd(nvac_pkg::OFS_CONTROL, 32'h0000_0008);
    POR <= 1'b1;
    cyc(1);
    POR <= 1'b0;
    cyc(1);
    rd(nvac_pkg::OFS_CONTROL, 32'h0000_0000);
    PGM_REQ <= 1'b1;
    cyc(4);
    chk({31'h0000_0000, PGM_GRANT}, 32'h0000_0001);
    chk({24'h00_0000, PGM_RDATA}, 32'h0000_00A5);
    CODE_PROTECT <= 1'b1;
    cyc(4);
    chk({31'h0000_0000, PGM_GRANT}, 32'h0000_0000);
    PGM_REQ <= 1'b0;
    eerd(8'hFF, 8'hC3);
    summarize();
  end
endmodule : eeprom_flash_access_ctrl_bench

// ### test/nvac_ctrl_monitor.sv
// port-level assertion checker for the nonvolatile access controller
`timescale 1ns/1ps
module nvac_ctrl_monitor #(
  parameter int PROG_WORDS   = 4096,
  parameter int WRITE_CYCLES = 8,
  parameter int ERASE_CYCLES = 4
) (
  input wire logic        CLK,          // core clock
  input wire logic        SYS_RST,      // sync reset
  input wire logic        EXT_RST,      // external reset
  input wire logic        CODE_PROTECT, // code protection
  input wire logic        PSEL,         // apb select
  input wire logic        PENABLE,      // apb access
  input wire logic        PWRITE,       // apb direction
  input wire logic [7:0]  PADDR,        // apb address
  input wire logic        PREADY,       // apb ready
  input wire logic [31:0] PRDATA,       // apb read data
  input wire logic        PGM_REQ,      // programmer request
  input wire logic        PGM_GRANT,    // programmer grant
  input wire logic        BUSY          // write running
);
  logic rd_ack;
  assign rd_ack = PSEL && PENABLE && PREADY && !PWRITE;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_data_low_byte: assert property (
    rd_ack && PADDR == nvac_pkg::OFS_DATA_LOW |-> PRDATA[31:8] == 24'h00_0000)
    else $error("data low read shows upper bits");
  a_data_high_six: assert property (
    rd_ack && PADDR == nvac_pkg::OFS_DATA_HIGH |-> PRDATA[31:6] == 26'h000_0000)
    else $error("data high read shows unimplemented bits");
  a_addr_high_five: assert property (
    rd_ack && PADDR == nvac_pkg::OFS_ADDR_HIGH |-> PRDATA[31:5] == 27'h000_0000)
    else $error("address high read shows unimplemented bits");
  a_unlock_reads_zero: assert property (
    rd_ack && PADDR == nvac_pkg::OFS_UNLOCK |-> PRDATA == 32'h0000_0000)
    else $error("unlock port read not zero");
  // busy cycles of the running write; restarted by an external cut
  logic [15:0] busy_cnt;
  always_ff @(posedge CLK) begin
    if (SYS_RST || EXT_RST || !BUSY) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= busy_cnt + 16'h0001;
    end
  end
  // external reset legally cuts a write short
  a_write_self_timed: assert property (disable iff (SYS_RST || EXT_RST)
    $fell(BUSY) && !$past(EXT_RST) |-> busy_cnt == 16'(WRITE_CYCLES))
    else $error("write cycle length wrong");
  a_wr_bit_held: assert property (
    rd_ack && PADDR == nvac_pkg::OFS_CONTROL && BUSY && $past(BUSY)
    |-> PRDATA[nvac_pkg::CTL_WR_BIT]) else $error("write bit clear while busy");
  a_protect_denies: assert property (
    CODE_PROTECT && $past(CODE_PROTECT) |-> !PGM_GRANT)
    else $error("programmer granted under protection");
  a_grant_needs_req: assert property (
    !PGM_REQ && !$past(PGM_REQ) |-> !PGM_GRANT)
    else $error("programmer granted without request");
  c_write: cover property ($rose(BUSY));
  c_grant: cover property (PGM_GRANT);
  c_ctl_read: cover property (rd_ack && PADDR == nvac_pkg::OFS_CONTROL && BUSY);
endmodule : nvac_ctrl_monitor

bind nvac_ctrl nvac_ctrl_monitor #(.PROG_WORDS(PROG_WORDS), .WRITE_CYCLES(WRITE_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) u_mon (.CLK(CLK), .SYS_RST(SYS_RST), .EXT_RST(EXT_RST),
  .CODE_PROTECT(CODE_PROTECT), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA), .PGM_REQ(PGM_REQ),
  .PGM_GRANT(PGM_GRANT), .BUSY(BUSY));
